/* File: logic/rmrt_params.svh */
// Function
// - Two ring ports, each full duplex
// - Port 0 carries control messages to processor
// - Port 1 carries data ring to network
// - One length header word per ring message
// - Length taken from low 16 header bits
// - Length one means address word only
// - Length zero header is discarded padding
// - Timeout abandons unacquirable ring receiver
// - Ring node addresses are 7 bits
// - Peripheral index is address bits 21-24
// - Peripheral entry: node, protocol, I-field
// - Replace node field of outgoing address word
// - Tag unit with protocol, send to I-field
// - Node replacement may be skipped
// - Arriving message goes to ring unchanged
// - Host index is 12-bit mailbox field
// - Host entry adds new mailbox number
// - Host style replaces mailbox field
// - One shared table of 4096 entries
// - Control address word carries an opcode
// - Current style used, mismatches not detected
`ifndef RMRT_PARAMS_SVH
`define RMRT_PARAMS_SVH

// ==========================================
// Word and header layout
`define RMRT_WORD_W 32
`define RMRT_LEN_W 16
`define RMRT_LEN_LSB 0

// ==========================================
// Ring address word fields
`define RMRT_NODE_W 7
`define RMRT_RAW_NODE_LSB 25
`define RMRT_PIDX_W 4
`define RMRT_RAW_PIDX_LSB 21
`define RMRT_MBOX_W 12
`define RMRT_RAW_MBOX_LSB 0
`define RMRT_OPC_W 8
`define RMRT_RAW_OPC_LSB 0

// ==========================================
// Address table geometry and entry layout
`define RMRT_TBL_DEPTH 4096
`define RMRT_TBL_AW 12
`define RMRT_PROTO_W 13
`define RMRT_IFIELD_W 32
`define RMRT_ENT_W 64
`define RMRT_ENT_IFIELD_LSB 0
`define RMRT_ENT_PROTO_LSB 32
`define RMRT_ENT_MBOX_LSB 45
`define RMRT_ENT_NODE_LSB 57

// ==========================================
// Timeout counter
`define RMRT_TO_W 32

`endif

/* File: logic/rmrt_pkg.sv */
// ==========================================
// Types of the ring message router
package rmrt_pkg;

    // Network-bound (ring to network) sequencer
    typedef enum logic [1:0] {
        NB_IDLE,
        NB_LOOK,
        NB_PASS
    } rmrt_nb_state_t;

    // Ring-bound (network to ring) sequencer
    typedef enum logic [2:0] {
        RB_HDR,
        RB_RAW,
        RB_ACQ,
        RB_BODY,
        RB_DROP
    } rmrt_rb_state_t;

    // Addressing style
    typedef enum logic {
        STYLE_PERIPH,
        STYLE_HOST
    } rmrt_style_t;

endpackage

/* File: logic/rmrt_top.sv */
`timescale 1ns/1ns
`include "rmrt_params.svh"

module rmrt_top (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    // Port 0 receive from ring (control messages)
    input wire logic i_cmd_rx_valid,
    input wire logic [`RMRT_WORD_W-1:0] i_cmd_rx_data,
    input wire logic i_cmd_rx_last,
    // Control messages delivered to processor
    output logic o_cpu_rx_valid,
    output logic [`RMRT_WORD_W-1:0] o_cpu_rx_data,
    output logic o_cpu_rx_last,
    output logic o_cpu_rx_first,
    output logic [`RMRT_OPC_W-1:0] o_cpu_rx_opcode,
    // Processor replies sent on port 0
    input wire logic i_cpu_tx_valid,
    input wire logic [`RMRT_WORD_W-1:0] i_cpu_tx_data,
    input wire logic i_cpu_tx_last,
    output logic o_cmd_tx_valid,
    output logic [`RMRT_WORD_W-1:0] o_cmd_tx_data,
    output logic o_cmd_tx_last,
    // Processor control: style, table, timeout
    input wire logic i_style_wr,
    input wire logic i_style_host,
    input wire logic i_keep_node,
    input wire logic i_tbl_wr,
    input wire logic [`RMRT_TBL_AW-1:0] i_tbl_addr,
    input wire logic [`RMRT_ENT_W-1:0] i_tbl_data,
    input wire logic [`RMRT_TO_W-1:0] i_timeout_cycles,
    input wire logic i_timeout_clr,
    output logic o_style_host,
    output logic o_timeout_flag,
    // Port 1 receive from ring (network-bound)
    input wire logic i_ring_rx_valid,
    input wire logic [`RMRT_WORD_W-1:0] i_ring_rx_data,
    input wire logic i_ring_rx_last,
    output logic o_ring_rx_ready,
    // Transfer unit words toward network
    output logic o_net_valid,
    output logic [`RMRT_WORD_W-1:0] o_net_data,
    output logic o_net_start,
    output logic o_net_last,
    output logic [`RMRT_PROTO_W-1:0] o_net_proto,
    output logic [`RMRT_IFIELD_W-1:0] o_net_ifield,
    // Encapsulated words from network (ring-bound)
    input wire logic i_net_rx_valid,
    input wire logic [`RMRT_WORD_W-1:0] i_net_rx_data,
    output logic o_net_rx_ready,
    // Port 1 transmit to ring with receiver acquisition
    input wire logic i_ring_tx_ack,
    output logic o_ring_tx_req,
    output logic o_ring_tx_valid,
    output logic [`RMRT_WORD_W-1:0] o_ring_tx_data,
    output logic o_ring_tx_last
);

    // ==========================================
    // Helper functions

    // Table index from address word in the current style
    function automatic logic [`RMRT_TBL_AW-1:0] table_index(
        input logic [`RMRT_WORD_W-1:0] raw,
        input rmrt_pkg::rmrt_style_t style
    );
        logic [`RMRT_TBL_AW-1:0] idx;
        idx = '0;
        if (style == rmrt_pkg::STYLE_HOST) begin
            idx = raw[`RMRT_RAW_MBOX_LSB +: `RMRT_MBOX_W];
        end else begin
            idx[`RMRT_PIDX_W-1:0] = raw[`RMRT_RAW_PIDX_LSB +: `RMRT_PIDX_W];
        end
        return idx;
    endfunction

    // Rewrite address word with table entry fields
    function automatic logic [`RMRT_WORD_W-1:0] rewrite_raw(
        input logic [`RMRT_WORD_W-1:0] raw,
        input logic [`RMRT_ENT_W-1:0] ent,
        input rmrt_pkg::rmrt_style_t style,
        input logic keep
    );
        logic [`RMRT_WORD_W-1:0] w;
        w = raw;
        if (!keep) begin
            // Node replacement, skippable for non-ring targets
            w[`RMRT_RAW_NODE_LSB +: `RMRT_NODE_W] =
                ent[`RMRT_ENT_NODE_LSB +: `RMRT_NODE_W];
        end
        if (style == rmrt_pkg::STYLE_HOST) begin
            w[`RMRT_RAW_MBOX_LSB +: `RMRT_MBOX_W] =
                ent[`RMRT_ENT_MBOX_LSB +: `RMRT_MBOX_W];
        end
        return w;
    endfunction

    // ==========================================
    // Declarations
    logic [`RMRT_ENT_W-1:0] net_address_table [0:`RMRT_TBL_DEPTH-1]; // Shared table
    logic [`RMRT_ENT_W-1:0] tbl_q; // Entry read for current message
    logic [`RMRT_WORD_W-1:0] raw_q; // Held network-bound address word
    logic raw_last_q; // Address word was the whole message
    rmrt_pkg::rmrt_nb_state_t nb_state; // Network-bound state
    rmrt_pkg::rmrt_rb_state_t rb_state; // Ring-bound state
    rmrt_pkg::rmrt_style_t style; // Current addressing style
    logic cmd_first; // Next port 0 word opens a message
    logic [`RMRT_LEN_W-1:0] rem; // Words left after the current one
    logic [`RMRT_WORD_W-1:0] rb_raw; // Held ring-bound address word
    logic [`RMRT_TO_W-1:0] to_cnt; // Acquisition wait counter
    logic ring_rx_take; // Port 1 word accepted
    logic net_rx_take; // Network word accepted
    logic timeout_hit; // Acquisition wait expires this cycle
    logic [`RMRT_LEN_W-1:0] hdr_len; // Length field of header word
    logic [`RMRT_TBL_AW-1:0] rd_idx; // Table read index

    assign ring_rx_take = i_ring_rx_valid && o_ring_rx_ready;
    assign net_rx_take = i_net_rx_valid && o_net_rx_ready;
    assign hdr_len = i_net_rx_data[`RMRT_LEN_LSB +: `RMRT_LEN_W];
    assign rd_idx = table_index(i_ring_rx_data, style);
    assign timeout_hit = (rb_state == rmrt_pkg::RB_ACQ) && !i_ring_tx_ack &&
                         (to_cnt + `RMRT_TO_W'(1) >= i_timeout_cycles);

    // ==========================================
    // Command port: control messages to the processor
    // Port 0 words go only to the processor; opcode taken from first word
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_cpu_rx_valid <= 1'b0;
            o_cpu_rx_data <= '0;
            o_cpu_rx_last <= 1'b0;
            o_cpu_rx_first <= 1'b0;
            o_cpu_rx_opcode <= '0;
            cmd_first <= 1'b1;
        end else begin
            o_cpu_rx_valid <= i_cmd_rx_valid;
            o_cpu_rx_data <= i_cmd_rx_data;
            o_cpu_rx_last <= i_cmd_rx_valid && i_cmd_rx_last;
            o_cpu_rx_first <= i_cmd_rx_valid && cmd_first;
            if (i_cmd_rx_valid && cmd_first) begin
                // Opcode field of the control address word
                o_cpu_rx_opcode <= i_cmd_rx_data[`RMRT_RAW_OPC_LSB +: `RMRT_OPC_W];
            end
            if (i_cmd_rx_valid) begin
                cmd_first <= i_cmd_rx_last;
            end
        end
    end

    // Processor replies onto port 0 transmit
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_cmd_tx_valid <= 1'b0;
            o_cmd_tx_data <= '0;
            o_cmd_tx_last <= 1'b0;
        end else begin
            o_cmd_tx_valid <= i_cpu_tx_valid;
            o_cmd_tx_data <= i_cpu_tx_data;
            o_cmd_tx_last <= i_cpu_tx_valid && i_cpu_tx_last;
        end
    end

    // ==========================================
    // Style selection and shared address table
    // Style is set by the processor after decoding a control message
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            style <= rmrt_pkg::STYLE_PERIPH;
        end else if (i_style_wr) begin
            style <= i_style_host ? rmrt_pkg::STYLE_HOST : rmrt_pkg::STYLE_PERIPH;
        end
    end

    // Style visible to the processor
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_style_host <= 1'b0;
        end else begin
            o_style_host <= (style == rmrt_pkg::STYLE_HOST);
        end
    end

    // One table for both styles; write from processor, read per message
    always_ff @(posedge i_clk) begin
        if (i_tbl_wr) begin
            net_address_table[i_tbl_addr] <= i_tbl_data;
        end
        if (ring_rx_take && nb_state == rmrt_pkg::NB_IDLE) begin
            tbl_q <= net_address_table[rd_idx];
        end
    end

    // ==========================================
    // Network-bound path: rewrite address word, tag, pass data
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            nb_state <= rmrt_pkg::NB_IDLE;
            o_ring_rx_ready <= 1'b1;
            raw_q <= '0;
            raw_last_q <= 1'b0;
            o_net_valid <= 1'b0;
            o_net_data <= '0;
            o_net_start <= 1'b0;
            o_net_last <= 1'b0;
            o_net_proto <= '0;
            o_net_ifield <= '0;
        end else begin
            o_net_valid <= 1'b0;
            o_net_start <= 1'b0;
            o_net_last <= 1'b0;
            unique case (nb_state)
                rmrt_pkg::NB_IDLE: begin
                    // Capture address word and stall while the table answers
                    if (ring_rx_take) begin
                        raw_q <= i_ring_rx_data;
                        raw_last_q <= i_ring_rx_last;
                        o_ring_rx_ready <= 1'b0;
                        nb_state <= rmrt_pkg::NB_LOOK;
                    end
                end
                rmrt_pkg::NB_LOOK: begin
                    // Emit rewritten address word with unit tags
                    o_net_valid <= 1'b1;
                    o_net_start <= 1'b1;
                    o_net_last <= raw_last_q;
                    o_net_data <= rewrite_raw(raw_q, tbl_q, style, i_keep_node);
                    o_net_proto <= tbl_q[`RMRT_ENT_PROTO_LSB +: `RMRT_PROTO_W];
                    o_net_ifield <= tbl_q[`RMRT_ENT_IFIELD_LSB +: `RMRT_IFIELD_W];
                    o_ring_rx_ready <= 1'b1;
                    nb_state <= raw_last_q ? rmrt_pkg::NB_IDLE : rmrt_pkg::NB_PASS;
                end
                rmrt_pkg::NB_PASS: begin
                    // Data words follow in the same transfer unit
                    if (ring_rx_take) begin
                        o_net_valid <= 1'b1;
                        o_net_data <= i_ring_rx_data;
                        o_net_last <= i_ring_rx_last;
                        if (i_ring_rx_last) begin
                            nb_state <= rmrt_pkg::NB_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // ==========================================
    // Ring-bound path: parse length headers, acquire, place on ring
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rb_state <= rmrt_pkg::RB_HDR;
            o_net_rx_ready <= 1'b1;
            rem <= '0;
            rb_raw <= '0;
            to_cnt <= '0;
            o_ring_tx_req <= 1'b0;
            o_ring_tx_valid <= 1'b0;
            o_ring_tx_data <= '0;
            o_ring_tx_last <= 1'b0;
        end else begin
            o_ring_tx_valid <= 1'b0;
            o_ring_tx_last <= 1'b0;
            unique case (rb_state)
                rmrt_pkg::RB_HDR: begin
                    // One header word per message; zero length is padding
                    if (net_rx_take && hdr_len != '0) begin
                        rem <= hdr_len - `RMRT_LEN_W'(1);
                        rb_state <= rmrt_pkg::RB_RAW;
                    end
                end
                rmrt_pkg::RB_RAW: begin
                    // Hold address word and request the ring receiver
                    if (net_rx_take) begin
                        rb_raw <= i_net_rx_data;
                        o_net_rx_ready <= 1'b0;
                        o_ring_tx_req <= 1'b1;
                        to_cnt <= '0;
                        rb_state <= rmrt_pkg::RB_ACQ;
                    end
                end
                rmrt_pkg::RB_ACQ: begin
                    if (i_ring_tx_ack) begin
                        // Acquired: send address word unchanged
                        o_ring_tx_req <= 1'b0;
                        o_ring_tx_valid <= 1'b1;
                        o_ring_tx_data <= rb_raw;
                        o_ring_tx_last <= (rem == '0);
                        o_net_rx_ready <= 1'b1;
                        rb_state <= (rem == '0) ? rmrt_pkg::RB_HDR : rmrt_pkg::RB_BODY;
                    end else if (timeout_hit) begin
                        // Give up and drain the rest of the message
                        o_ring_tx_req <= 1'b0;
                        o_net_rx_ready <= 1'b1;
                        rb_state <= (rem == '0) ? rmrt_pkg::RB_HDR : rmrt_pkg::RB_DROP;
                    end else begin
                        to_cnt <= to_cnt + `RMRT_TO_W'(1);
                    end
                end
                rmrt_pkg::RB_BODY: begin
                    // Data words pass straight to the ring
                    if (net_rx_take) begin
                        o_ring_tx_valid <= 1'b1;
                        o_ring_tx_data <= i_net_rx_data;
                        o_ring_tx_last <= (rem == `RMRT_LEN_W'(1));
                        rem <= rem - `RMRT_LEN_W'(1);
                        if (rem == `RMRT_LEN_W'(1)) begin
                            rb_state <= rmrt_pkg::RB_HDR;
                        end
                    end
                end
                rmrt_pkg::RB_DROP: begin
                    // Abandoned message words are consumed silently
                    if (net_rx_take) begin
                        rem <= rem - `RMRT_LEN_W'(1);
                        if (rem == `RMRT_LEN_W'(1)) begin
                            rb_state <= rmrt_pkg::RB_HDR;
                        end
                    end
                end
            endcase
        end
    end

    // Sticky expiry flag; a new expiry wins over a clear
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_timeout_flag <= 1'b0;
        end else if (timeout_hit) begin
            o_timeout_flag <= 1'b1;
        end else if (i_timeout_clr) begin
            o_timeout_flag <= 1'b0;
        end
    end

    // ==========================================
    // Assertions
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);

    zero_hdr_drop_a: assert property (
        (rb_state == rmrt_pkg::RB_HDR && net_rx_take && hdr_len == '0)
        |=> (rb_state == rmrt_pkg::RB_HDR) && !o_ring_tx_valid && !o_ring_tx_req)
        else $error("zero length header not discarded");

    len_one_last_a: assert property (
        (rb_state == rmrt_pkg::RB_ACQ && i_ring_tx_ack && rem == '0)
        |=> o_ring_tx_valid && o_ring_tx_last && rb_state == rmrt_pkg::RB_HDR)
        else $error("single word message not closed");

    timeout_flag_a: assert property (
        timeout_hit |=> o_timeout_flag && !o_ring_tx_req && o_net_rx_ready)
        else $error("timeout did not flag and release");

    acq_stall_a: assert property (
        (rb_state == rmrt_pkg::RB_ACQ) |-> !o_net_rx_ready && o_ring_tx_req)
        else $error("input not stalled during acquisition");

    node_rewrite_a: assert property (
        (nb_state == rmrt_pkg::NB_LOOK && !i_keep_node)
        |=> o_net_start && o_net_data[`RMRT_RAW_NODE_LSB +: `RMRT_NODE_W] ==
            $past(tbl_q[`RMRT_ENT_NODE_LSB +: `RMRT_NODE_W]))
        else $error("node field not replaced");

    host_mbox_a: assert property (
        (nb_state == rmrt_pkg::NB_LOOK && style == rmrt_pkg::STYLE_HOST)
        |=> o_net_data[`RMRT_RAW_MBOX_LSB +: `RMRT_MBOX_W] ==
            $past(tbl_q[`RMRT_ENT_MBOX_LSB +: `RMRT_MBOX_W]))
        else $error("mailbox field not replaced");

    unit_tag_a: assert property (
        (nb_state == rmrt_pkg::NB_LOOK)
        |=> o_net_proto == $past(tbl_q[`RMRT_ENT_PROTO_LSB +: `RMRT_PROTO_W]) &&
            o_net_ifield == $past(tbl_q[`RMRT_ENT_IFIELD_LSB +: `RMRT_IFIELD_W]))
        else $error("unit tags not from table");

    periph_index_a: assert property (
        (style == rmrt_pkg::STYLE_PERIPH)
        |-> rd_idx == {8'h00, i_ring_rx_data[24:21]})
        else $error("peripheral index wrong");

    cmd_route_a: assert property (
        i_cmd_rx_valid |=> o_cpu_rx_valid && o_cpu_rx_data == $past(i_cmd_rx_data))
        else $error("control word not routed to processor");

    ring_pass_a: assert property (
        (rb_state == rmrt_pkg::RB_BODY && net_rx_take)
        |=> o_ring_tx_valid && o_ring_tx_data == $past(i_net_rx_data))
        else $error("ring-bound word altered");

    host_msg_c: cover property (
        nb_state == rmrt_pkg::NB_LOOK && style == rmrt_pkg::STYLE_HOST ##1 o_net_start);
    timeout_c: cover property (timeout_hit);
    pad_hdr_c: cover property (rb_state == rmrt_pkg::RB_HDR && net_rx_take && hdr_len == '0);
    body_c: cover property (rb_state == rmrt_pkg::RB_BODY ##1 rb_state == rmrt_pkg::RB_HDR);

endmodule

/* File: sim/rmrt_ring_node.sv */
`timescale 1ns/1ns

// =====================================================
// Ring receiver that the data port acquires
module rmrt_ring_node (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    // Acquisition handshake
    input wire logic i_req,
    output logic o_ack,
    // Behaviour controls from the bench
    input wire logic i_dead,
    input wire logic [3:0] i_delay
);
    logic [3:0] wait_cnt; // Cycles the request has stood

    // Acknowledge after a delay, or never when the node is absent
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wait_cnt <= 4'h0;
            o_ack <= 1'b0;
        end else if (!i_req) begin
            // Released: drop the acquisition at once
            wait_cnt <= 4'h0;
            o_ack <= 1'b0;
        end else begin
            if (wait_cnt != 4'hf) begin
                wait_cnt <= wait_cnt + 4'h1;
            end
            o_ack <= !i_dead && (wait_cnt >= i_delay);
        end
    end
endmodule

/* File: sim/tb.sv */
`timescale 1ns/1ns
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin error_cnt++; $display("FAIL at %0t: got %h expected %h", $time, (g), (e)); end end

module tb;
    // =====================================================
    // Stimulus, all but i_ring_tx_ack given a value at time zero
    logic i_clk = 1'b0, i_arst_n = 1'b0;
    logic i_cmd_rx_valid = 1'b0, i_cmd_rx_last = 1'b0, i_cpu_tx_valid = 1'b0, i_cpu_tx_last = 1'b0;
    logic [31:0] i_cmd_rx_data = 32'h0, i_cpu_tx_data = 32'h0;
    logic [31:0] i_ring_rx_data = 32'h0, i_net_rx_data = 32'h0, i_timeout_cycles = 32'h4;
    logic i_style_wr = 1'b0, i_style_host = 1'b0, i_keep_node = 1'b0, i_tbl_wr = 1'b0;
    logic i_timeout_clr = 1'b0, i_ring_rx_valid = 1'b0, i_ring_rx_last = 1'b0, i_net_rx_valid = 1'b0;
    logic [11:0] i_tbl_addr = 12'h0;
    logic [63:0] i_tbl_data = 64'h0;
    logic i_ring_tx_ack; // Driven by the ring node model
    logic node_dead = 1'b0; // Ring node never answers when set
    // Design outputs
    logic o_cpu_rx_valid, o_cpu_rx_last, o_cpu_rx_first, o_cmd_tx_valid, o_cmd_tx_last;
    logic [31:0] o_cpu_rx_data, o_cmd_tx_data, o_net_data, o_ring_tx_data, o_net_ifield;
    logic [7:0] o_cpu_rx_opcode;
    logic [12:0] o_net_proto;
    logic o_style_host, o_timeout_flag, o_ring_rx_ready, o_net_valid, o_net_start, o_net_last;
    logic o_net_rx_ready, o_ring_tx_req, o_ring_tx_valid, o_ring_tx_last;
    // Bookkeeping and captured traffic
    int error_cnt = 0, n_checks = 0, cyc = 0;
    logic [78:0] netq[$]; // start, last, proto, ifield, data
    logic [32:0] ringq[$]; // last, data

    rmrt_top i_rmrt_top (.*);
    rmrt_ring_node i_rmrt_ring_node (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_req(o_ring_tx_req),
        .o_ack(i_ring_tx_ack), .i_dead(node_dead), .i_delay(4'h1));

    // =====================================================
    // Clock, reset and main sequence
    initial begin
        forever #10 i_clk = ~i_clk;
    end
    initial begin
        repeat (10) @(posedge i_clk);
        i_arst_n <= 1'b1;
        t_cmd_port();
        t_periph();
        t_host();
        t_ring_bound();
        t_timeout();
        conclude();
    end

    // Capture one-cycle outputs and cut a hang short
    always @(posedge i_clk) begin
        if (o_net_valid === 1'b1) begin
            netq.push_back({o_net_start, o_net_last, o_net_proto, o_net_ifield, o_net_data});
        end
        if (o_ring_tx_valid === 1'b1) begin
            ringq.push_back({o_ring_tx_last, o_ring_tx_data});
        end
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            conclude();
        end
    end

    // =====================================================
    // Shared tasks
    task conclude;
        if (error_cnt == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // Send words on the ring or network side, each held until accepted
    task push(input bit net, input logic [31:0] q[$]);
        bit rdy;
        @(posedge i_clk);
        foreach (q[k]) begin
            if (net) begin
                i_net_rx_valid <= 1'b1;
                i_net_rx_data <= q[k];
            end else begin
                i_ring_rx_valid <= 1'b1;
                i_ring_rx_data <= q[k];
                i_ring_rx_last <= (k == q.size() - 1);
            end
            rdy = 1'b0;
            while (!rdy) begin
                @(negedge i_clk);
                rdy = net ? o_net_rx_ready : o_ring_rx_ready;
                @(posedge i_clk);
            end
        end
        i_net_rx_valid <= 1'b0;
        i_ring_rx_valid <= 1'b0;
        i_ring_rx_last <= 1'b0;
    endtask

    // Wait, bounded, until n words were captured, then a little longer
    task wait_q(input int n);
        int k;
        k = 0;
        while (netq.size() + ringq.size() < n && k < 40) begin
            @(posedge i_clk);
            k++;
        end
        repeat (3) @(posedge i_clk);
    endtask

    task tbl(input logic [11:0] a, input logic [63:0] d);
        @(posedge i_clk);
        i_tbl_wr <= 1'b1;
        i_tbl_addr <= a;
        i_tbl_data <= d;
        @(posedge i_clk);
        i_tbl_wr <= 1'b0;
    endtask

    task style(input logic h);
        @(posedge i_clk);
        i_style_wr <= 1'b1;
        i_style_host <= h;
        @(posedge i_clk);
        i_style_wr <= 1'b0;
    endtask

    // =====================================================
    // Scenarios
    // Command port: two words back to back, reply path alongside
    task t_cmd_port;
        @(posedge i_clk);
        i_cmd_rx_valid <= 1'b1;
        i_cmd_rx_data <= 32'h1234_5642;
        i_cpu_tx_valid <= 1'b1;
        i_cpu_tx_data <= 32'h0bad_cafe;
        i_cpu_tx_last <= 1'b1;
        @(posedge i_clk);
        i_cmd_rx_data <= 32'h0000_00aa;
        i_cmd_rx_last <= 1'b1;
        i_cpu_tx_valid <= 1'b0;
        #1;
        `CHK({o_cpu_rx_valid, o_cpu_rx_first, o_cpu_rx_data}, {2'b11, 32'h1234_5642});
        `CHK({o_cmd_tx_valid, o_cmd_tx_last, o_cmd_tx_data}, {2'b11, 32'h0bad_cafe});
        @(posedge i_clk);
        i_cmd_rx_valid <= 1'b0;
        i_cmd_rx_last <= 1'b0;
        #1;
        `CHK({o_cpu_rx_valid, o_cpu_rx_first, o_cpu_rx_last, o_cpu_rx_opcode}, 11'h542);
        `CHK(o_cmd_tx_valid, 1'b0);
    endtask

    // Peripheral style: index from bits 24..21, node replaced
    task t_periph;
        style(1'b0);
        tbl(12'h009, {7'h15, 12'h000, 13'h1abc, 32'hcafe_0001});
        netq.delete();
        push(1'b0, '{{7'h7f, 4'h9, 21'h01234}, 32'h1111_2222});
        wait_q(2);
        `CHK(o_style_host, 1'b0);
        `CHK(netq[0], {2'b10, 13'h1abc, 32'hcafe_0001, 7'h15, 4'h9, 21'h01234});
        `CHK(netq[1], {2'b01, 13'h1abc, 32'hcafe_0001, 32'h1111_2222});
    endtask

    // Host style: mailbox index, shared table, node kept on request
    task t_host;
        style(1'b1);
        tbl(12'h3c5, {7'h2a, 12'h7e1, 13'h0555, 32'h0bad_f00d});
        netq.delete();
        push(1'b0, '{{7'h01, 13'h0abc, 12'h3c5}});
        wait_q(1);
        push(1'b0, '{{7'h01, 13'h0abc, 12'h009}});
        wait_q(2);
        i_keep_node <= 1'b1;
        push(1'b0, '{{7'h01, 13'h0abc, 12'h3c5}});
        wait_q(3);
        i_keep_node <= 1'b0;
        `CHK(o_style_host, 1'b1);
        `CHK(netq[0], {2'b11, 13'h0555, 32'h0bad_f00d, 7'h2a, 13'h0abc, 12'h7e1});
        `CHK(netq[1], {2'b11, 13'h1abc, 32'hcafe_0001, 7'h15, 13'h0abc, 12'h000});
        `CHK(netq[2], {2'b11, 13'h0555, 32'h0bad_f00d, 7'h01, 13'h0abc, 12'h7e1});
    endtask

    // Ring-bound: padding header, upper header bits set, address-only message
    task t_ring_bound;
        ringq.delete();
        netq.delete();
        push(1'b1, '{32'h0, 32'h5a5a_0002, 32'h8123_4567, 32'h0000_beef, 32'h1, 32'h7654_3210});
        wait_q(3);
        `CHK(ringq.size(), 3);
        `CHK(ringq[0], {1'b0, 32'h8123_4567});
        `CHK(ringq[1], {1'b1, 32'h0000_beef});
        `CHK(ringq[2], {1'b1, 32'h7654_3210});
    endtask

    // Absent receiver: abandon, flag, swallow the body, then recover
    task t_timeout;
        node_dead <= 1'b1;
        ringq.delete();
        push(1'b1, '{32'h3, 32'h0e00_0001, 32'h1, 32'h2});
        repeat (3) @(posedge i_clk);
        #1;
        `CHK({o_timeout_flag, o_ring_tx_req, o_net_rx_ready, o_ring_rx_ready}, 4'b1011);
        `CHK(ringq.size(), 0);
        node_dead <= 1'b0;
        @(posedge i_clk);
        i_timeout_clr <= 1'b1;
        @(posedge i_clk);
        i_timeout_clr <= 1'b0;
        #1;
        `CHK(o_timeout_flag, 1'b0);
        push(1'b1, '{32'h1, 32'h0e00_0002});
        wait_q(1);
        `CHK(ringq[0], {1'b1, 32'h0e00_0002});
    endtask
endmodule
